// *** inc/iss_pkg.sv ***
// Package of constants for the init status sequencer
package iss_pkg;
    // Bank count, also the width of each per-bank field
    localparam int          NUM_BANKS       = 4;
    // Register byte offsets
    localparam logic [3:0]  CTRL_OFFSET     = 4'h0;
    localparam logic [3:0]  INIT_CFG_OFFSET = 4'h4;
    localparam logic [3:0]  STATUS_OFFSET   = 4'h8;
    // Control field positions
    localparam int          CTRL_AVM_BIT    = 0;
    localparam int          CTRL_MASK_LSB   = 4;
    // Init config field positions, each 8 bits wide
    localparam int          CFG_PCIE_LSB    = 0;
    localparam int          CFG_XCVR_LSB    = 8;
    localparam int          CFG_LSRAM_LSB   = 16;
    // Status field positions
    localparam int          ST_INIT_BIT     = 0;
    localparam int          ST_CALIB_BIT    = 1;
    localparam int          ST_AVM_BIT      = 2;
    localparam int          ST_TMO_BIT      = 3;
    localparam int          ST_SUPPLY_LSB   = 4;
    localparam int          ST_DONE_LSB     = 8;
    localparam int          ST_APPROX_LSB   = 12;
    // Reset values
    localparam logic [31:0] CTRL_RESET      = 32'h0000_00f0;
    localparam logic [31:0] INIT_CFG_RESET  = 32'h0010_1010;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // Timing: clock rate and times in their own units
    localparam int          CLK_MHZ         = 25;
    localparam int          CALIB_TIME_US   = 40;
    localparam int          CAL_TIMEOUT_US  = 1000;
    localparam int          CALIB_CYC       = CALIB_TIME_US * CLK_MHZ;
    localparam int          CAL_TIMEOUT_CYC = CAL_TIMEOUT_US * CLK_MHZ;
    // Init sequencer states
    typedef enum logic [1:0] {
        ISS_HOLD = 2'b00,
        ISS_RUN  = 2'b01,
        ISS_DONE = 2'b10
    } iss_init_state_t;
endpackage

// *** rtl/iss_init_status_sequencer.sv ***
// Init status sequencer: calibration, avionics and bank supply flags
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module iss_init_status_sequencer #(
    parameter int CAL_TIMEOUT_CYC = iss_pkg::CAL_TIMEOUT_CYC
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic                          external_device_reset_n,
    input  wire logic                          tamper_reset_request,
    input  wire logic [iss_pkg::NUM_BANKS-1:0] bank_supply_raw,
    input  wire logic                          recalibration_request,
    output logic      [iss_pkg::NUM_BANKS-1:0] bank_supply_ok,
    output logic                               init_complete_flag,
    output logic                               calibration_complete_flag,
    output logic                               avionics_active_flag,
    input  wire logic [31:0]                   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic      [1:0]                    s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [31:0]                   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic      [31:0]                   s_axi_rdata,
    output logic      [1:0]                    s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready
);
    localparam int NB = iss_pkg::NUM_BANKS;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn); // Checks idle while cold reset holds

    logic [1:0]                  rst_sync_reg;
    logic [1:0]                  tmp_sync_reg;
    logic [NB-1:0]               sup_meta_reg;
    logic [NB-1:0]               sup_sync_reg;
    logic                        warm_start;
    logic [31:0]                 ctrl_reg;
    logic [31:0]                 cfg_reg;
    logic                        avm_enable;
    logic [NB-1:0]               desig_mask;
    iss_pkg::iss_init_state_t    state_reg;
    logic [9:0]                  init_cnt_reg;
    logic [9:0]                  init_len;
    logic [15:0]                 tmo_cnt_reg;
    logic                        tmo_reg;
    logic [NB-1:0]               cal_run_reg;
    logic [NB-1:0]               cal_done_reg;
    logic [NB-1:0]               approx_reg;
    logic [NB-1:0]               late_reg;
    logic [9:0]                  cal_cnt_reg [NB];
    logic                        all_done;
    logic                        aw_held_reg;
    logic                        w_held_reg;
    logic [3:0]                  aw_addr_reg;
    logic [31:0]                 w_data_reg;
    logic [3:0]                  w_strb_reg;
    logic [31:0]                 status_word;

    // Pin synchronisers; only the second stage is read by logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_sync_reg <= 2'h3;
            tmp_sync_reg <= 2'h0;
            sup_meta_reg <= '0;
            sup_sync_reg <= '0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], external_device_reset_n};
            tmp_sync_reg <= {tmp_sync_reg[0], tamper_reset_request};
            sup_meta_reg <= bank_supply_raw;
            sup_sync_reg <= sup_meta_reg;
        end
    end

    // Either warm source restarts the whole sequence
    assign warm_start = !rst_sync_reg[1] || tmp_sync_reg[1];

    // Bank readiness shown per bank, not by the fabric reset release
    assign bank_supply_ok = sup_sync_reg;

    assign avm_enable = ctrl_reg[iss_pkg::CTRL_AVM_BIT];
    assign desig_mask = ctrl_reg[iss_pkg::CTRL_MASK_LSB +: NB];
    assign init_len   = 10'(cfg_reg[iss_pkg::CFG_PCIE_LSB +: 8])
                      + 10'(cfg_reg[iss_pkg::CFG_XCVR_LSB +: 8])
                      + 10'(cfg_reg[iss_pkg::CFG_LSRAM_LSB +: 8]);

    // Auto-init sequencer; length set by configured PCIe, XCVR, LSRAM work
    always_ff @(posedge aclk) begin
        if (!aresetn || warm_start) begin
            state_reg    <= iss_pkg::ISS_HOLD;
            init_cnt_reg <= '0;
        end else begin
            case (state_reg)
                iss_pkg::ISS_HOLD: begin
                    state_reg <= iss_pkg::ISS_RUN;
                end
                iss_pkg::ISS_RUN: begin
                    if (init_cnt_reg >= init_len) begin
                        state_reg <= iss_pkg::ISS_DONE;
                    end else begin
                        init_cnt_reg <= init_cnt_reg + 10'h1;
                    end
                end
                iss_pkg::ISS_DONE: begin
                    state_reg <= iss_pkg::ISS_DONE;
                end
                default: begin
                    state_reg <= iss_pkg::ISS_HOLD;
                end
            endcase
        end
    end

    // Calibration timeout window, counted from reset release
    always_ff @(posedge aclk) begin
        if (!aresetn || warm_start) begin
            tmo_cnt_reg <= '0;
            tmo_reg     <= 1'b0;
        end else if (!tmo_reg) begin
            if (tmo_cnt_reg == 16'(CAL_TIMEOUT_CYC - 1)) begin
                tmo_reg <= 1'b1;
            end else begin
                tmo_cnt_reg <= tmo_cnt_reg + 16'h1;
            end
        end
    end

    // Per-bank calibration engine, runs beside auto-init
    generate
        for (genvar i = 0; i < NB; i++) begin : g_bank
            always_ff @(posedge aclk) begin
                if (!aresetn || warm_start) begin
                    cal_run_reg[i]  <= 1'b0;
                    cal_done_reg[i] <= 1'b0;
                    approx_reg[i]   <= 1'b0;
                    late_reg[i]     <= 1'b0;
                    cal_cnt_reg[i]  <= '0;
                end else if (recalibration_request && desig_mask[i]
                             && sup_sync_reg[i]) begin
                    // Fabric restart yields an accurate result
                    cal_run_reg[i]  <= 1'b1;
                    cal_done_reg[i] <= 1'b0;
                    approx_reg[i]   <= 1'b0;
                    late_reg[i]     <= 1'b0;
                    cal_cnt_reg[i]  <= '0;
                end else if (cal_run_reg[i]) begin
                    if (cal_cnt_reg[i] == 10'(iss_pkg::CALIB_CYC - 1)) begin
                        cal_run_reg[i]  <= 1'b0;
                        cal_done_reg[i] <= 1'b1;
                        approx_reg[i]   <= late_reg[i];
                    end else begin
                        cal_cnt_reg[i] <= cal_cnt_reg[i] + 10'h1;
                    end
                end else if (desig_mask[i] && sup_sync_reg[i]
                             && !cal_done_reg[i]) begin
                    // Only a start after the window is approximate
                    cal_run_reg[i] <= 1'b1;
                    late_reg[i]    <= tmo_reg;
                    cal_cnt_reg[i] <= '0;
                end
            end
        end
    endgenerate

    assign all_done = &(cal_done_reg | ~desig_mask);

    // Sticky status flags; cleared only by cold or warm reset
    always_ff @(posedge aclk) begin
        if (!aresetn || warm_start) begin
            init_complete_flag        <= 1'b0;
            calibration_complete_flag <= 1'b0;
            avionics_active_flag      <= 1'b0;
        end else begin
            if (state_reg == iss_pkg::ISS_DONE) begin
                init_complete_flag <= 1'b1;
            end
            // No look at init here: the two flags race freely
            if (all_done || tmo_reg) begin
                calibration_complete_flag <= 1'b1;
            end
            if (avm_enable && init_complete_flag
                && calibration_complete_flag) begin
                avionics_active_flag <= 1'b1;
            end
        end
    end

    // AXI write: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr[3:0];
            end else if (aw_held_reg && w_held_reg) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (aw_held_reg && w_held_reg) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Register update and write response; status and unmapped are refused
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg     <= iss_pkg::CTRL_RESET;
            cfg_reg      <= iss_pkg::INIT_CFG_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= iss_pkg::RESP_OKAY;
        end else if (aw_held_reg && w_held_reg) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= iss_pkg::RESP_OKAY;
            for (int b = 0; b < 4; b++) begin
                if (w_strb_reg[b] && aw_addr_reg == iss_pkg::CTRL_OFFSET) begin
                    ctrl_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
                end
                if (w_strb_reg[b]
                    && aw_addr_reg == iss_pkg::INIT_CFG_OFFSET) begin
                    cfg_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
                end
            end
            if (aw_addr_reg != iss_pkg::CTRL_OFFSET
                && aw_addr_reg != iss_pkg::INIT_CFG_OFFSET) begin
                s_axi_bresp <= iss_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Status word reflects live sequencer state
    assign status_word = {16'h0,
                          approx_reg, cal_done_reg, sup_sync_reg,
                          tmo_reg, avionics_active_flag,
                          calibration_complete_flag, init_complete_flag};

    // AXI read: one outstanding read, answer the cycle after address
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= iss_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= iss_pkg::RESP_OKAY;
            case (s_axi_araddr[3:0])
                iss_pkg::CTRL_OFFSET:     s_axi_rdata <= ctrl_reg;
                iss_pkg::INIT_CFG_OFFSET: s_axi_rdata <= cfg_reg;
                iss_pkg::STATUS_OFFSET:   s_axi_rdata <= status_word;
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= iss_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks on the flag behaviour
    AST_SUPPLY_FLAG: assert property (
        $past(aresetn) && $past(aresetn, 2)
        |-> bank_supply_ok == $past(bank_supply_raw, 2))
        else $error("bank supply flag does not follow supply pins");
    AST_CALIB_NEEDS_BANKS: assert property (
        $rose(calibration_complete_flag) |-> $past(all_done || tmo_reg))
        else $error("calibration complete rose with banks outstanding");
    AST_CALIB_NO_INIT_WAIT: assert property (
        !warm_start && all_done && !calibration_complete_flag
        |=> calibration_complete_flag)
        else $error("calibration complete waited on something else");
    AST_TIMEOUT_HOLD: assert property (
        !all_done && !tmo_reg && !calibration_complete_flag
        |=> !calibration_complete_flag)
        else $error("calibration complete rose before timeout");
    AST_LATE_APPROX: assert property (
        $rose(cal_done_reg[1]) && $past(late_reg[1]) |-> approx_reg[1])
        else $error("late bank not marked approximate");
    AST_AVM_OFF: assert property (
        !$past(avm_enable) && !$past(avionics_active_flag)
        |-> !avionics_active_flag)
        else $error("avionics flag rose with mode unused");
    AST_AVM_LATER: assert property (
        avm_enable && init_complete_flag && calibration_complete_flag
        && !warm_start |=> avionics_active_flag)
        else $error("avionics flag late");
    AST_WARM_CLEARS: assert property (
        warm_start |=> !init_complete_flag && !calibration_complete_flag
        && !avionics_active_flag)
        else $error("warm restart did not clear flags");
    AST_INIT_LENGTH: assert property (
        $rose(init_complete_flag) |-> $past(init_cnt_reg, 2) >= init_len
        || $past(init_cnt_reg) >= init_len)
        else $error("init complete before configured init length");
    AST_STICKY: assert property (
        $fell(calibration_complete_flag) || $fell(init_complete_flag)
        |-> $past(warm_start))
        else $error("status flag dropped without reset");

    COV_CALIB_FIRST: cover property (
        $rose(calibration_complete_flag) && !init_complete_flag);
    COV_INIT_FIRST: cover property (
        $rose(calibration_complete_flag) && init_complete_flag);
    COV_TIMEOUT: cover property (
        $rose(calibration_complete_flag) && tmo_reg && !all_done);
    COV_AVM: cover property ($rose(avionics_active_flag));
endmodule

// *** test/iss_fabric_model.sv ***
// Fabric-side partner: consumes status flags and requests recalibration
`timescale 1ns/1ps
module iss_fabric_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       warm_reset_active,
    input  wire logic       recal_go,
    input  wire logic [2:0] flags,
    output logic            recalibration_request,
    output logic [7:0]      drop_count
);
    logic [2:0] flags_q;

    // Request follows recal_go one cycle late; a held level would keep restarting
    always_ff @(posedge aclk) begin
        recalibration_request <= recal_go && aresetn;
    end

    // A flag falling outside any reset is a stickiness fault
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q    <= 3'h0;
            drop_count <= 8'h00;
        end else begin
            flags_q <= flags;
            if (!warm_reset_active && |(flags_q & ~flags)) begin
                drop_count <= drop_count + 8'h01;
            end
        end
    end
endmodule

// *** test/test_init_status_sequencer.sv ***
// Self-checking bench for the init status sequencer
`timescale 1ns/1ps
module test_init_status_sequencer;
    localparam int TMO = 2000; // Shortened timeout, still above calibration
    logic aclk = 1'b0, aresetn = 1'b0, ext_rst_n = 1'b1, tamper = 1'b0;
    logic [3:0] supply_raw = 4'hf, supply_ok;
    logic recal_req, recal_go = 1'b0, init_f, calib_f, avm_f;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic awready, wready, arready, bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [7:0] drops;
    int failures = 0, checked = 0;

    always #20 aclk = ~aclk;

    iss_init_status_sequencer #(.CAL_TIMEOUT_CYC(TMO))
    iss_init_status_sequencer_i (
        .aclk(aclk), .aresetn(aresetn), .external_device_reset_n(ext_rst_n),
        .tamper_reset_request(tamper), .bank_supply_raw(supply_raw),
        .recalibration_request(recal_req), .bank_supply_ok(supply_ok),
        .init_complete_flag(init_f), .calibration_complete_flag(calib_f),
        .avionics_active_flag(avm_f), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));

    iss_fabric_model iss_fabric_model_i (
        .aclk(aclk), .aresetn(aresetn),
        .warm_reset_active(!ext_rst_n || tamper), .recal_go(recal_go),
        .flags({avm_f, calib_f, init_f}), .recalibration_request(recal_req),
        .drop_count(drops));

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Address and data offered together; each released once taken
    // Waits end only on the answer; the watchdog catches a hang
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                             input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge aclk);
        end while (!bvalid);
        check({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                            input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
        end while (!arready);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
        end while (!rvalid);
        d = rdata;
        check({30'h0, rresp}, {30'h0, er});
    endtask

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog sized well above the roughly 5500 cycles of the tests
    initial begin
        tick(20000);
        failures++;
        wrap_up();
    end

    initial begin
        logic [31:0] v;
        int n;
        tick(4);
        aresetn <= 1'b1;
        tick(1);
        axi_read(32'h0, v, 2'h0);
        check(v, iss_pkg::CTRL_RESET);
        axi_read(32'h4, v, 2'h0);
        check(v, iss_pkg::INIT_CFG_RESET);
        axi_read(32'hc, v, 2'h2);
        check(v, 32'h0);
        axi_write(32'h8, 32'hffff_ffff, 2'h2);
        $display("test register_map done");
        // Init at about 51 cycles, calibration about 1000 cycles later
        tick(90);
        check({29'h0, init_f, calib_f, avm_f}, 32'h4);
        check({28'h0, supply_ok}, 32'hf);
        tick(1000);
        check({29'h0, init_f, calib_f, avm_f}, 32'h6);
        $display("test cold_start done");
        // Empty mask: calibration first, init later, avionics follows init
        axi_write(32'h0, 32'h0000_0001, 2'h0);
        axi_write(32'h4, 32'h0040_4040, 2'h0);
        tamper <= 1'b1;
        tick(4);
        check({30'h0, init_f, calib_f}, 32'h0);
        tamper <= 1'b0;
        tick(20);
        check({29'h0, init_f, calib_f, avm_f}, 32'h2);
        n = 0;
        while (!init_f && n < 400) begin
            tick(1);
            n++;
        end
        check({30'h0, init_f, avm_f}, 32'h2);
        tick(2);
        check({31'h0, avm_f}, 32'h1);
        $display("test avionics_order done");
        // Bank 1 designated but unpowered: held low until the timeout
        supply_raw <= 4'b1101;
        axi_write(32'h0, 32'h0000_0031, 2'h0);
        ext_rst_n <= 1'b0;
        tick(4);
        check({29'h0, init_f, calib_f, avm_f}, 32'h0);
        ext_rst_n <= 1'b1;
        tick(1500);
        check({31'h0, calib_f}, 32'h0);
        axi_read(32'h8, v, 2'h0);
        check(v & 32'h0000_030b, 32'h0000_0101);
        tick(600);
        axi_read(32'h8, v, 2'h0);
        check(v & 32'h0000_000f, 32'h0000_000f);
        supply_raw <= 4'hf;
        tick(3);
        check({28'h0, supply_ok}, 32'hf);
        tick(1010);
        axi_read(32'h8, v, 2'h0);
        check(v & 32'h0000_2200, 32'h0000_2200);
        $display("test late_bank done");
        // Fabric asks for a fresh calibration; flags must not drop
        recal_go <= 1'b1;
        tick(1);
        recal_go <= 1'b0;
        tick(1010);
        axi_read(32'h8, v, 2'h0);
        check(v & 32'h0000_2207, 32'h0000_0207);
        check({24'h0, drops}, 32'h0);
        $display("test recalibration done");
        wrap_up();
    end
endmodule
